// File: common/async_fmt_pkg.sv
// async_fmt_pkg: shared constants and types for the asynchronous packet
// builder (host writer end and device framer end).
// assumes: both ends compile after this package.
`default_nettype none
package async_fmt_pkg;
  // ****************************************
  // fifo write address codes (packet position)
  // ****************************************
  localparam logic [1:0] POS_FIRST = 2'h0;
  localparam logic [1:0] POS_MID = 2'h1;
  localparam logic [1:0] POS_LAST = 2'h2;
  localparam logic [1:0] POS_ONLY = 2'h3;
  // ****************************************
  // header quadlet fields, bit 0 = lsb (bit 0 msb in big-endian view)
  // ****************************************
  localparam int SPD_LSB = 16;
  localparam int LABEL_LSB = 10;
  localparam int RETRY_LSB = 8;
  localparam int TCODE_LSB = 4;
  localparam int PRIO_LSB = 0;
  localparam int DEST_LSB = 16;
  localparam int RCODE_LSB = 12;
  localparam int LEN_LSB = 16;
  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] SPD_100 = 2'h0;
  localparam logic [1:0] SPD_200 = 2'h1;
  localparam logic [1:0] SPD_400 = 2'h2;
  localparam logic [1:0] SPD_UNDEF = 2'h3;
  localparam logic [1:0] RETRY_NEW = 2'h0;
  localparam logic [1:0] RETRY_X = 2'h1;
  localparam logic [1:0] RETRY_A = 2'h2;
  localparam logic [1:0] RETRY_B = 2'h3;
  // transaction codes that decide the layout
  localparam logic [3:0] TC_WR_QUAD = 4'h0;
  localparam logic [3:0] TC_WR_BLOCK = 4'h1;
  localparam logic [3:0] TC_WR_RESP = 4'h2;
  localparam logic [3:0] TC_RD_QUAD = 4'h4;
  localparam logic [3:0] TC_RD_BLOCK = 4'h5;
  localparam logic [3:0] TC_RD_QRESP = 4'h6;
  localparam logic [3:0] TC_RD_BRESP = 4'h7;
  localparam logic [3:0] TC_LOCK_REQ = 4'h9;
  localparam logic [3:0] TC_LOCK_RESP = 4'hB;
  localparam logic [3:0] PRIO_CABLE = 4'h0;
  localparam logic [15:0] ZERO_LEN = 16'h0000;
  localparam logic [1:0] QUAD_LOW_BITS = 2'h0;
  localparam logic [15:0] LEN_WIDTH16 = 16'h0003;

  typedef enum logic [2:0] {
    ST_CTRL = 3'h0,
    ST_ADDR_HI = 3'h1,
    ST_ADDR_LO = 3'h3,
    ST_LEN = 3'h2,
    ST_DATA = 3'h6,
    ST_DROP = 3'h7
  } frame_state_t;
endpackage
`default_nettype wire

// File: common/async_fifo_if.sv
// async_fifo_if: transmit fifo write path between host and framer.
// assumes: one clock shared by both ends.
`default_nettype none
interface async_fifo_if (
  input wire logic clock
);
  logic wr_valid;
  logic wr_ready;
  logic [1:0] wr_pos;
  logic [31:0] wr_data;
  modport host (output wr_valid, output wr_pos, output wr_data,
    input wr_ready);
  modport device (input wr_valid, input wr_pos, input wr_data,
    output wr_ready);
endinterface
`default_nettype wire

// File: hw/async_framer.sv
// async_framer: device end; takes quadlets from the transmit fifo port,
// splits them by position code and emits decoded serial-bus header fields.
// assumes: the host keeps the write layout; one clock, async reset.
//
// Behaviour
// - accept quadlet and block transmit layouts
// - fifo address marks first, middle, last quadlet
// - block payload byte count from length field
// - host sends control, two address, optional data
// - no data quadlet for reads, write responses
// - outgoing headers built from loaded header quadlets
// - speed code selects 100, 200, 400 Mbit/s
// - retry code new, X, A, B
// - host gives unique label per outstanding transaction
// - host writes zero priority on cable
// - destination is 10-bit bus, 6-bit node
// - host keeps destination offset quadlet aligned
// - lock response carries code in offset top
// - length upper half, extended code lower half
// - zero length means no payload quadlets
// - first payload byte in byte 0
`default_nettype none
module async_framer
  import async_fmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  async_fifo_if.device fifo,
  output var logic hdr_valid,
  output var logic [2:0] hdr_rate_sel,
  output var logic hdr_is_block,
  output var logic [5:0] hdr_label,
  output var logic [1:0] hdr_retry,
  output var logic [3:0] hdr_tcode,
  output var logic [3:0] hdr_prio,
  output var logic [9:0] hdr_bus,
  output var logic [5:0] hdr_node,
  output var logic [47:0] hdr_offset,
  output var logic [3:0] hdr_rcode,
  output var logic [15:0] hdr_length,
  output var logic [15:0] hdr_ext_tcode,
  output var logic pay_valid,
  output var logic [31:0] pay_data,
  output var logic [2:0] pay_bytes,
  output var logic pkt_end,
  output var logic fmt_error
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    frame_state_t st;
    logic is_block;
    logic has_data;
    logic [15:0] remain;
    logic hv;
    logic [2:0] rate;
    logic [5:0] label;
    logic [1:0] retry;
    logic [3:0] tcode;
    logic [3:0] prio;
    logic [9:0] bus;
    logic [5:0] node;
    logic [47:0] offset;
    logic [3:0] rcode;
    logic [15:0] length;
    logic [15:0] ext;
    logic pv;
    logic [31:0] pd;
    logic [2:0] pb;
    logic pe;
    logic err;
  } framer_t;

  framer_t s_r;
  framer_t s_nxt;
  logic take;
  logic [31:0] q;

  assign take = fifo.wr_valid;
  assign q = fifo.wr_data;
  // framer never stalls, so the fifo port is always open
  assign fifo.wr_ready = 1'b1;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.hv = 1'b0;
    s_nxt.pv = 1'b0;
    s_nxt.pe = 1'b0;
    s_nxt.err = 1'b0;
    if (take) begin
      // a first-position code always restarts framing
      if (fifo.wr_pos == POS_FIRST || fifo.wr_pos == POS_ONLY) begin
        s_nxt.st = ST_ADDR_HI;
        s_nxt.err = (s_r.st != ST_CTRL) || (fifo.wr_pos == POS_ONLY);
        s_nxt.label = q[LABEL_LSB +: 6];
        s_nxt.retry = q[RETRY_LSB +: 2];
        s_nxt.tcode = q[TCODE_LSB +: 4];
        s_nxt.prio = q[PRIO_LSB +: 4];
        case (q[SPD_LSB +: 2])
          SPD_100: s_nxt.rate = 3'h1;
          SPD_200: s_nxt.rate = 3'h2;
          SPD_400: s_nxt.rate = 3'h4;
          default: s_nxt.rate = 3'h0;
        endcase
        // layout chosen by transaction code
        s_nxt.is_block = (q[TCODE_LSB +: 4] == TC_WR_BLOCK) ||
          (q[TCODE_LSB +: 4] == TC_RD_BRESP) ||
          (q[TCODE_LSB +: 4] == TC_LOCK_REQ) ||
          (q[TCODE_LSB +: 4] == TC_LOCK_RESP) ||
          (q[TCODE_LSB +: 4] == TC_RD_BLOCK);
        // quadlet data only for write request, read response
        s_nxt.has_data = (q[TCODE_LSB +: 4] == TC_WR_QUAD) ||
          (q[TCODE_LSB +: 4] == TC_RD_QRESP);
        if (fifo.wr_pos == POS_ONLY) begin
          s_nxt.st = ST_CTRL;
        end
      end else begin
        case (s_r.st)
          ST_ADDR_HI: begin
            s_nxt.bus = q[DEST_LSB + 6 +: 10];
            s_nxt.node = q[DEST_LSB +: 6];
            s_nxt.offset[47:32] = q[15:0];
            s_nxt.rcode = (s_r.tcode == TC_LOCK_RESP) ?
              q[RCODE_LSB +: 4] : 4'h0;
            s_nxt.st = ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            s_nxt.offset[31:0] = q;
            if (s_r.is_block) begin
              s_nxt.st = ST_LEN;
            end else if (s_r.has_data) begin
              s_nxt.st = ST_DATA;
              s_nxt.remain = 16'h0004;
            end else begin
              // header complete; packet must end here
              s_nxt.hv = 1'b1;
              s_nxt.length = ZERO_LEN;
              s_nxt.pe = 1'b1;
              s_nxt.err = (fifo.wr_pos != POS_LAST);
              s_nxt.st = ST_CTRL;
            end
          end
          ST_LEN: begin
            s_nxt.length = q[LEN_LSB +: 16];
            s_nxt.ext = q[15:0];
            s_nxt.remain = q[LEN_LSB +: 16];
            s_nxt.hv = 1'b1;
            if (q[LEN_LSB +: 16] == ZERO_LEN) begin
              s_nxt.pe = 1'b1;
              s_nxt.err = (fifo.wr_pos != POS_LAST);
              s_nxt.st = ST_CTRL;
            end else begin
              s_nxt.st = ST_DATA;
            end
          end
          ST_DATA: begin
            if (!s_r.is_block && s_r.remain == 16'h0004) begin
              s_nxt.hv = 1'b1;
              s_nxt.length = ZERO_LEN;
            end
            // byte 0 of the quadlet is the first payload byte
            s_nxt.pv = 1'b1;
            s_nxt.pd = q;
            s_nxt.pb = (s_r.remain > 16'h0003) ? 3'h4 :
              s_r.remain[2:0];
            s_nxt.remain = (s_r.remain > 16'h0003) ?
              s_r.remain - 16'h0004 : ZERO_LEN;
            if (s_r.remain <= 16'h0004) begin
              s_nxt.pe = 1'b1;
              s_nxt.err = (fifo.wr_pos != POS_LAST);
              s_nxt.st = ST_CTRL;
            end else if (fifo.wr_pos == POS_LAST) begin
              // host ended early: close packet, flag it
              s_nxt.pe = 1'b1;
              s_nxt.err = 1'b1;
              s_nxt.st = ST_CTRL;
            end
          end
          ST_DROP: begin
            if (fifo.wr_pos == POS_LAST) begin
              s_nxt.st = ST_CTRL;
            end
          end
          default: begin
            // stray middle or last with no open packet
            s_nxt.err = 1'b1;
            s_nxt.st = (fifo.wr_pos == POS_LAST) ? ST_CTRL : ST_DROP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hdr_valid = s_r.hv;
  assign hdr_rate_sel = s_r.rate;
  assign hdr_is_block = s_r.is_block;
  assign hdr_label = s_r.label;
  assign hdr_retry = s_r.retry;
  assign hdr_tcode = s_r.tcode;
  assign hdr_prio = s_r.prio;
  assign hdr_bus = s_r.bus;
  assign hdr_node = s_r.node;
  assign hdr_offset = s_r.offset;
  assign hdr_rcode = s_r.rcode;
  assign hdr_length = s_r.length;
  assign hdr_ext_tcode = s_r.ext;
  assign pay_valid = s_r.pv;
  assign pay_data = s_r.pd;
  assign pay_bytes = s_r.pb;
  assign pkt_end = s_r.pe;
  assign fmt_error = s_r.err;
endmodule
`default_nettype wire

// File: hw/async_writer.sv
// async_writer: host end; serialises a packet request into fifo writes
// with position codes.
// assumes: payload is presented one quadlet per accepted beat.
`default_nettype none
module async_writer
  import async_fmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  async_fifo_if.host fifo,
  input wire logic req_valid,
  output var logic req_ready,
  input wire logic [1:0] req_speed,
  input wire logic [5:0] req_label,
  input wire logic [1:0] req_retry,
  input wire logic [3:0] req_tcode,
  input wire logic [9:0] req_bus,
  input wire logic [5:0] req_node,
  input wire logic [47:0] req_offset,
  input wire logic [3:0] req_rcode,
  input wire logic [15:0] req_length,
  input wire logic [15:0] req_ext_tcode,
  input wire logic [31:0] pay_in,
  output var logic pay_take
);
  typedef struct packed {
    frame_state_t st;
    logic blk;
    logic dat;
    logic [15:0] remain;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] len;
    logic v;
    logic [1:0] pos;
    logic [31:0] d;
    logic rdy;
    logic tk;
  } writer_t;

  writer_t s_r;
  writer_t s_nxt;
  logic go;
  logic moved;

  assign moved = s_r.v && fifo.wr_ready;
  assign go = req_valid && s_r.rdy;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tk = 1'b0;
    s_nxt.rdy = 1'b0;
    if (moved) begin
      s_nxt.v = 1'b0;
    end
    if (go) begin
      // control quadlet with cable priority zero
      s_nxt.d = '0;
      s_nxt.d[SPD_LSB +: 2] = req_speed;
      s_nxt.d[LABEL_LSB +: 6] = req_label;
      s_nxt.d[RETRY_LSB +: 2] = req_retry;
      s_nxt.d[TCODE_LSB +: 4] = req_tcode;
      s_nxt.d[PRIO_LSB +: 4] = PRIO_CABLE;
      s_nxt.v = 1'b1;
      s_nxt.pos = POS_FIRST;
      s_nxt.blk = (req_tcode == TC_WR_BLOCK) ||
        (req_tcode == TC_RD_BRESP) || (req_tcode == TC_LOCK_REQ) ||
        (req_tcode == TC_LOCK_RESP) || (req_tcode == TC_RD_BLOCK);
      s_nxt.dat = (req_tcode == TC_WR_QUAD) ||
        (req_tcode == TC_RD_QRESP);
      s_nxt.hi = {req_bus, req_node, req_offset[47:32]};
      if (req_tcode == TC_LOCK_RESP) begin
        s_nxt.hi[RCODE_LSB +: 4] = req_rcode;
      end
      s_nxt.lo = {req_offset[31:2], QUAD_LOW_BITS};
      s_nxt.len = {req_length, req_ext_tcode};
      s_nxt.remain = req_length;
      s_nxt.st = ST_ADDR_HI;
    end else if (!s_r.v || moved) begin
      case (s_r.st)
        ST_ADDR_HI: begin
          s_nxt.v = 1'b1;
          s_nxt.pos = POS_MID;
          s_nxt.d = s_r.hi;
          s_nxt.st = ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          s_nxt.v = 1'b1;
          s_nxt.d = s_r.lo;
          s_nxt.pos = (s_r.blk || s_r.dat) ? POS_MID : POS_LAST;
          s_nxt.st = s_r.blk ? ST_LEN : (s_r.dat ? ST_DATA : ST_CTRL);
          s_nxt.remain = s_r.blk ? s_r.remain : 16'h0004;
          s_nxt.rdy = !(s_r.blk || s_r.dat);
        end
        ST_LEN: begin
          s_nxt.v = 1'b1;
          s_nxt.d = s_r.len;
          // zero length sends no payload
          s_nxt.pos = (s_r.remain == ZERO_LEN) ? POS_LAST : POS_MID;
          s_nxt.st = (s_r.remain == ZERO_LEN) ? ST_CTRL : ST_DATA;
          s_nxt.rdy = (s_r.remain == ZERO_LEN);
        end
        ST_DATA: begin
          // payload passed unchanged, first byte in byte 0
          s_nxt.v = 1'b1;
          s_nxt.d = pay_in;
          s_nxt.tk = 1'b1;
          s_nxt.pos = (s_r.remain <= 16'h0004) ? POS_LAST : POS_MID;
          s_nxt.remain = (s_r.remain > 16'h0004) ?
            s_r.remain - 16'h0004 : ZERO_LEN;
          s_nxt.st = (s_r.remain <= 16'h0004) ? ST_CTRL : ST_DATA;
          s_nxt.rdy = (s_r.remain <= 16'h0004);
        end
        ST_CTRL: begin
          s_nxt.rdy = !req_valid || !s_r.rdy;
        end
        default: begin
          s_nxt.st = ST_CTRL;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fifo.wr_valid = s_r.v;
  assign fifo.wr_pos = s_r.pos;
  assign fifo.wr_data = s_r.d;
  assign req_ready = s_r.rdy;
  assign pay_take = s_r.tk;
endmodule
`default_nettype wire

// File: sim/async_fifo_props.sv
// async_fifo_props: timing checks on the transmit fifo write path
// assumes: instantiated beside the interface that joins both ends
`default_nettype none
module async_fifo_props
  import async_fmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [1:0] wr_pos,
  input wire logic [31:0] wr_data
);
  // ********
  // helpers
  // ********
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  logic hd, blk;
  logic [3:0] tc;
  assign tc = wr_data[TCODE_LSB+:4];
  assign hd = wr_valid && wr_pos == POS_FIRST;
  assign blk = tc inside {TC_WR_BLOCK, TC_RD_BLOCK, TC_RD_BRESP,
    TC_LOCK_REQ, TC_LOCK_RESP};
  // ********
  // properties
  // ********
  // a taken last quadlet closes the packet; only a new first may follow
  a_last_first: assert property (wr_valid && wr_ready && wr_pos == POS_LAST
    |=> !wr_valid || wr_pos == POS_FIRST)
    else $error("packet continued after last quadlet");
  a_no_single: assert property (wr_valid |-> wr_pos != POS_ONLY)
    else $error("single position code written");
  a_hdr_words: assert property (hd |=> wr_valid && wr_pos == POS_MID
    ##1 wr_valid && wr_pos != POS_FIRST)
    else $error("header quadlets broken");
  a_prio_zero: assert property (hd |-> wr_data[PRIO_LSB+:4] == 4'h0)
    else $error("priority not zero");
  a_addr_align: assert property (hd ##1 wr_valid ##1 wr_valid
    |-> wr_data[1:0] == QUAD_LOW_BITS)
    else $error("offset not quadlet aligned");
  a_read_three: assert property (hd && (tc == TC_RD_QUAD
    || tc == TC_WR_RESP) |-> ##2 wr_pos == POS_LAST)
    else $error("no-data packet not ended after address");
  a_qdata_four: assert property (hd && (tc == TC_WR_QUAD
    || tc == TC_RD_QRESP) |-> ##2 wr_pos == POS_MID
    ##1 wr_valid && wr_pos == POS_LAST)
    else $error("data quadlet packet not four long");
  a_zero_len: assert property (hd && blk ##3 (wr_valid
    && wr_data[LEN_LSB+:16] == ZERO_LEN) |-> wr_pos == POS_LAST)
    else $error("payload follows zero length");
  a_len_more: assert property (hd && blk ##3 (wr_valid
    && wr_data[LEN_LSB+:16] != ZERO_LEN) |-> wr_pos == POS_MID)
    else $error("block ended at length quadlet");
endmodule
`default_nettype wire

// File: sim/async_packet_format_builder_test.sv
// async_packet_format_builder_test: writer and framer back to back
// assumes: one clock; a second framer is fed directly by the bench
`default_nettype none
module async_packet_format_builder_test
  import async_fmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // signals
  // ********
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, pay_take, pay_valid, pkt_end, b_hdr, b_fail;
  logic [1:0] req_speed = 2'h0, req_retry = 2'h0, hdr_retry;
  logic [5:0] req_label = 6'h00, req_node = 6'h1B, hdr_label, hdr_node;
  logic [3:0] req_tcode = 4'h0, req_rcode = 4'h0;
  logic [3:0] hdr_tcode, hdr_prio, hdr_rcode;
  logic [9:0] req_bus = 10'h2A5, hdr_bus;
  logic [47:0] req_offset = 48'hABCD_1234_5678, hdr_offset;
  logic [15:0] req_length = 16'h0000, req_ext_tcode = 16'h0000;
  logic [15:0] hdr_length, hdr_ext_tcode;
  logic [31:0] pay_in = 32'h0, pay_data;
  logic [2:0] hdr_rate_sel, pay_bytes;
  logic hdr_is_block;
  logic hdr_valid, fmt_error;
  int errors = 0, samples_checked = 0, cycles = 0;
  int ends = 0, b_hdrs = 0, b_fails = 0;
  int hdrs = 0, fails = 0;
  logic [31:0] pq[$], src[$];
  logic [2:0] bq[$];
  async_fifo_if f1 (.clock(clock));
  async_fifo_if f2 (.clock(clock));
  async_writer i_async_writer (.clock, .arst_n, .fifo(f1), .req_valid,
    .req_ready, .req_speed, .req_label, .req_retry, .req_tcode, .req_bus,
    .req_node, .req_offset, .req_rcode, .req_length, .req_ext_tcode,
    .pay_in, .pay_take);
  async_framer i_async_framer (.clock, .arst_n, .fifo(f1), .hdr_valid,
    .hdr_rate_sel, .hdr_is_block, .hdr_label, .hdr_retry, .hdr_tcode,
    .hdr_prio, .hdr_bus, .hdr_node, .hdr_offset, .hdr_rcode, .hdr_length,
    .hdr_ext_tcode, .pay_valid, .pay_data, .pay_bytes, .pkt_end,
    .fmt_error);
  async_framer i_async_framer_b (.clock, .arst_n, .fifo(f2),
    .hdr_valid(b_hdr), .hdr_rate_sel(), .hdr_is_block(), .hdr_label(),
    .hdr_retry(), .hdr_tcode(), .hdr_prio(), .hdr_bus(), .hdr_node(),
    .hdr_offset(), .hdr_rcode(), .hdr_length(), .hdr_ext_tcode(),
    .pay_valid(), .pay_data(), .pay_bytes(), .pkt_end(),
    .fmt_error(b_fail));
  async_fifo_props i_async_fifo_props (.clock, .arst_n,
    .wr_valid(f1.wr_valid), .wr_ready(f1.wr_ready), .wr_pos(f1.wr_pos),
    .wr_data(f1.wr_data));
  initial forever #25 clock = ~clock;
  // ********
  // monitor and payload source
  // ********
  always @(negedge clock) begin
    if (pay_valid === 1'b1) begin
      pq.push_back(pay_data);
      bq.push_back(pay_bytes);
    end
    if (pkt_end === 1'b1) ends++;
    if (b_hdr === 1'b1) b_hdrs++;
    if (b_fail === 1'b1) b_fails++;
    if (hdr_valid === 1'b1) hdrs++;
    if (fmt_error === 1'b1) fails++;
    // the writer has consumed pay_in once pay_take shows
    if (pay_take === 1'b1 && src.size() > 0) begin
      void'(src.pop_front());
      if (src.size() > 0) pay_in = src[0];
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  // ********
  // tasks
  // ********
  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(logic [3:0] tc, logic [1:0] sp, logic [15:0] len,
      logic [3:0] rc);
    int n, h, f;
    logic blk;
    n = ends;
    h = hdrs;
    f = fails;
    blk = tc inside {TC_WR_BLOCK, TC_RD_BLOCK, TC_RD_BRESP, TC_LOCK_REQ,
      TC_LOCK_RESP};
    pq.delete();
    bq.delete();
    req_tcode = tc;
    req_speed = sp;
    req_retry = sp;
    req_length = len;
    req_rcode = rc;
    req_ext_tcode = 16'h0002 + len;
    // a fresh label for every outstanding transaction
    req_label = req_label + 6'h01;
    req_bus = req_bus ^ 10'h3C3;
    pay_in = src.size() > 0 ? src[0] : 32'h0;
    req_valid = 1'b1;
    repeat (20) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    @(negedge clock);
    req_valid = 1'b0;
    for (int i = 0; i < 60 && ends == n; i++) @(negedge clock);
    check("pkt_end", ends - n, 1);
    check("hdr_valid", hdrs - h, 1);
    check("fmt_error", fails - f, 0);
    check("rate", hdr_rate_sel, sp == SPD_UNDEF ? 3'h0 : 3'h1 << sp);
    check("retry", hdr_retry, sp);
    check("label", hdr_label, req_label);
    check("tcode", hdr_tcode, tc);
    check("prio", hdr_prio, PRIO_CABLE);
    check("bus", hdr_bus, req_bus);
    check("node", hdr_node, req_node);
    check("offset", hdr_offset[43:0], req_offset[43:0]);
    check("block", hdr_is_block, blk);
    check("rcode", hdr_rcode, tc == TC_LOCK_RESP ? rc : 4'h0);
    if (blk) begin
      check("length", hdr_length, len);
      check("ext", hdr_ext_tcode, 16'h0002 + len);
    end else begin
      check("length", hdr_length, ZERO_LEN);
    end
  endtask
  task automatic t_rates();
    for (int i = 0; i < 4; i++) begin
      send(TC_RD_QUAD, i[1:0], 16'h0000, 4'h0);
      check("no pay", pq.size(), 0);
    end
  endtask
  task automatic t_quads();
    src = '{32'hCAFE_0001};
    send(TC_WR_QUAD, SPD_200, 16'h0000, 4'h0);
    check("quad beats", pq.size(), 1);
    check("quad data", pq[0], 32'hCAFE_0001);
    check("quad bytes", bq[0], 3'h4);
    send(TC_WR_RESP, SPD_100, 16'h0000, 4'h0);
    check("resp beats", pq.size(), 0);
    src = '{32'hCAFE_0002};
    send(TC_RD_QRESP, SPD_400, 16'h0000, 4'h0);
    check("qresp beats", pq.size(), 1);
    check("qresp data", pq[0], 32'hCAFE_0002);
  endtask
  task automatic t_block();
    src = '{32'h1122_3344, 32'h5566_7788};
    send(TC_WR_BLOCK, SPD_400, 16'h0006, 4'h0);
    check("beats", pq.size(), 2);
    check("first", pq[0], 32'h1122_3344);
    check("bytes0", bq[0], 3'h4);
    check("bytes1", bq[1], 3'h2);
    check("second", pq[1], 32'h5566_7788);
  endtask
  task automatic t_empty();
    send(TC_RD_BLOCK, SPD_100, ZERO_LEN, 4'h0);
    check("empty", pq.size(), 0);
  endtask
  task automatic t_lock();
    src = '{32'h0BAD_F00D};
    send(TC_LOCK_RESP, SPD_200, 16'h0004, 4'hA);
    check("lock beats", pq.size(), 1);
    check("lock data", pq[0], 32'h0BAD_F00D);
  endtask
  task automatic put(logic [1:0] pos, logic [31:0] d);
    f2.wr_valid = 1'b1;
    f2.wr_pos = pos;
    f2.wr_data = d;
    repeat (5) begin
      @(posedge clock);
      if (f2.wr_ready === 1'b1) break;
    end
    @(negedge clock);
  endtask
  task automatic t_stray();
    int e, h;
    e = b_fails;
    h = b_hdrs;
    // stray middle, a single-position quadlet, a clean read request,
    // then a block cut short by an early last
    put(POS_MID, 32'h0000_0000);
    put(POS_LAST, 32'h0000_0000);
    put(POS_ONLY, {24'h000000, TC_RD_QUAD, PRIO_CABLE});
    put(POS_FIRST, {24'h000000, TC_RD_QUAD, PRIO_CABLE});
    put(POS_MID, {16'h1234, 16'h0000});
    put(POS_LAST, 32'h0000_0010);
    put(POS_FIRST, {24'h000000, TC_WR_BLOCK, PRIO_CABLE});
    put(POS_MID, {16'h1234, 16'h0000});
    put(POS_MID, 32'h0000_0010);
    put(POS_MID, {16'h0008, 16'h0000});
    put(POS_LAST, 32'h0BAD_F00D);
    f2.wr_valid = 1'b0;
    repeat (3) @(negedge clock);
    check("stray error", b_fails - e, 3);
    check("stray header", b_hdrs - h, 2);
  endtask
  initial begin
    f2.wr_valid = 1'b0;
    f2.wr_pos = POS_FIRST;
    f2.wr_data = 32'h0;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    repeat (2) @(negedge clock);
    t_rates();
    t_quads();
    t_block();
    t_empty();
    t_lock();
    t_stray();
    conclude();
  end
endmodule
`default_nettype wire
